// ### inc/rar_pkg.sv
// constants for the per-port i2c alias remap block
package rar_pkg;
   localparam int RAR_NUM_PORTS = 4;
   localparam int RAR_NUM_SLOTS = 8;
   localparam logic [7:0] RAR_PHYS_BASE = 8'h5d;
   localparam logic [7:0] RAR_ALIAS_BASE = 8'h65;
   localparam logic [7:0] RAR_REMOTE_TARGET_ADDR_6 = 8'h63;
   localparam logic [7:0] RAR_REMOTE_TARGET_ADDR_7 = 8'h64;
   localparam logic [7:0] RAR_LOCAL_ALIAS_ADDR_0 = 8'h65;
   localparam logic [7:0] RAR_LOCAL_ALIAS_ADDR_1 = 8'h66;
   localparam int RAR_ADDR_MSB = 7;
   localparam int RAR_ADDR_LSB = 1;
   localparam int RAR_AUTO_ACK_BIT = 0;
   localparam int RAR_RW_BIT = 0;
   localparam logic [7:0] RAR_ALIAS_RESET = 8'h00;
   localparam logic [6:0] RAR_PHYS_RESET = 7'h00;
   localparam logic [7:0] RAR_UNMAPPED_READ = 8'h00;
endpackage

// ### src/rar_slot_match.sv
// alias comparator over all port and slot entries, lowest entry wins
module rar_slot_match #(
   parameter int NUM_ENTRIES = 32,
   parameter int ENTRY_W = 5
) (
   // programmed aliases, entry k in bits 7k+6:7k
   input wire logic [NUM_ENTRIES*7-1:0] alias_flat,
   // incoming 7-bit address
   input wire logic [6:0] probe,
   // result
   output logic hit,
   output logic [ENTRY_W-1:0] idx
);
   if (NUM_ENTRIES < 1 || (1 << ENTRY_W) < NUM_ENTRIES) begin : g_chk
      $error("entry index too narrow for the entry count");
   end

   always_comb begin
      hit = 1'b0;
      idx = '0;
      for (int k = NUM_ENTRIES - 1; k >= 0; k--) begin
         // a zero alias never matches
         if (alias_flat[k*7 +: 7] != 7'h00 && alias_flat[k*7 +: 7] == probe) begin
            hit = 1'b1;
            idx = ENTRY_W'(k);
         end
      end
   end
endmodule // rar_slot_match

// ### src/rar_alias_remap.sv
// per-receive-port i2c alias match and target address substitution
// How it works
// - register reads and writes land in the copy of the receive port chosen by port_sel.
// - a matching address has its 7 bits replaced by the paired target address before forwarding.
// - every incoming address is compared against each programmed 7-bit alias in bits 7:1.
// - an alias of zero matches nothing and so forwards nothing.
// - with auto-ack bit 0 set, every write to that target is acknowledged locally at once.
// - alias slot n pairs only with target slot n of the same port.
// - all alias and target fields are zero after reset.
// - bit 0 of each target register reads zero and ignores writes.
// - alias slots follow one another at consecutive offsets from the slot-0 alias register.
module rar_alias_remap
#(
   parameter int NUM_PORTS = rar_pkg::RAR_NUM_PORTS,
   parameter int NUM_SLOTS = rar_pkg::RAR_NUM_SLOTS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register access from the local i2c target
   input wire logic [$clog2(NUM_PORTS)-1:0] port_sel,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_ff,
   // local transaction stream
   input wire logic addr_valid,
   input wire logic [7:0] addr_byte,
   input wire logic data_valid,
   input wire logic [7:0] data_byte,
   input wire logic txn_stop,
   // acknowledge from the serializer
   input wire logic remote_ack_valid,
   input wire logic remote_ack,
   // forwarded stream to the control channel
   output logic fwd_addr_valid_ff,
   output logic [7:0] fwd_addr_ff,
   output logic [$clog2(NUM_PORTS)-1:0] fwd_port_ff,
   output logic fwd_data_valid_ff,
   output logic [7:0] fwd_data_ff,
   output logic miss_ff,
   // acknowledge back to the local controller
   output logic local_ack_valid_ff,
   output logic local_ack_ff,
   output logic txn_active_ff
);
   import rar_pkg::*;

   localparam int PORT_W = $clog2(NUM_PORTS);
   localparam int SLOT_W = $clog2(NUM_SLOTS);
   localparam int ENTRIES = NUM_PORTS * NUM_SLOTS;
   localparam int ENTRY_W = PORT_W + SLOT_W;

   // the target window must end below the alias window
   if (NUM_PORTS < 2 || (NUM_PORTS & (NUM_PORTS - 1)) != 0 ||
       NUM_SLOTS < 2 || (NUM_SLOTS & (NUM_SLOTS - 1)) != 0 ||
       NUM_SLOTS > int'(RAR_ALIAS_BASE - RAR_PHYS_BASE)) begin : g_chk
      $error("port and slot counts must be powers of two, slot windows must not overlap");
   end

   logic [7:0] alias_ff [NUM_PORTS][NUM_SLOTS];
   logic [6:0] phys_ff [NUM_PORTS][NUM_SLOTS];
   logic auto_write_ff;

   // register window decode
   function automatic logic slot_hit(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] diff;
      diff = 8'(a - base);
      return diff < 8'(NUM_SLOTS);
   endfunction

   function automatic logic [SLOT_W-1:0] slot_idx(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] diff;
      diff = 8'(a - base);
      return diff[SLOT_W-1:0];
   endfunction

   logic wr_alias_hit, wr_phys_hit;
   logic [SLOT_W-1:0] alias_sel, phys_sel;

   always_comb begin
      wr_alias_hit = slot_hit(reg_addr, RAR_ALIAS_BASE);
      wr_phys_hit = slot_hit(reg_addr, RAR_PHYS_BASE);
      alias_sel = slot_idx(reg_addr, RAR_ALIAS_BASE);
      phys_sel = slot_idx(reg_addr, RAR_PHYS_BASE);
   end

   // register storage, one copy per receive port
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
               alias_ff[p][s] <= RAR_ALIAS_RESET;
               phys_ff[p][s] <= RAR_PHYS_RESET;
            end
         end
      end else if (reg_wr_en) begin
         if (wr_alias_hit) begin
            alias_ff[port_sel][alias_sel] <= reg_wdata;
         end
         if (wr_phys_hit) begin
            // bit 0 is not stored
            phys_ff[port_sel][phys_sel] <= reg_wdata[RAR_ADDR_MSB:RAR_ADDR_LSB];
         end
      end
   end

   logic [7:0] rd_value;

   always_comb begin
      rd_value = RAR_UNMAPPED_READ;
      if (wr_alias_hit) begin
         rd_value = alias_ff[port_sel][alias_sel];
      end else if (wr_phys_hit) begin
         rd_value = {phys_ff[port_sel][phys_sel], 1'b0};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rdata_ff <= rd_value;
      end
   end

   // alias compare across all ports and slots
   logic [ENTRIES*7-1:0] alias_flat;
   logic match_hit;
   logic [ENTRY_W-1:0] match_idx;
   logic [PORT_W-1:0] hit_port;
   logic [SLOT_W-1:0] hit_slot;
   logic [6:0] hit_phys;
   logic hit_auto;

   always_comb begin
      alias_flat = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int s = 0; s < NUM_SLOTS; s++) begin
            alias_flat[(p*NUM_SLOTS + s)*7 +: 7] = alias_ff[p][s][RAR_ADDR_MSB:RAR_ADDR_LSB];
         end
      end
   end

   rar_slot_match #(
      .NUM_ENTRIES(ENTRIES),
      .ENTRY_W(ENTRY_W)
   ) u_match (
      .alias_flat(alias_flat),
      .probe(addr_byte[RAR_ADDR_MSB:RAR_ADDR_LSB]),
      .hit(match_hit),
      .idx(match_idx)
   );

   always_comb begin
      hit_port = match_idx[ENTRY_W-1:SLOT_W];
      hit_slot = match_idx[SLOT_W-1:0];
      hit_phys = phys_ff[hit_port][hit_slot];
      hit_auto = alias_ff[hit_port][hit_slot][RAR_AUTO_ACK_BIT];
   end

   logic new_hit, new_auto_write;

   always_comb begin
      new_hit = addr_valid && match_hit;
      new_auto_write = new_hit && hit_auto && !addr_byte[RAR_RW_BIT];
   end

   // address forwarding with substitution
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fwd_addr_valid_ff <= 1'b0;
         fwd_addr_ff <= 8'h00;
         fwd_port_ff <= '0;
         miss_ff <= 1'b0;
      end else begin
         fwd_addr_valid_ff <= new_hit;
         miss_ff <= addr_valid && !match_hit;
         if (new_hit) begin
            fwd_addr_ff <= {hit_phys, addr_byte[RAR_RW_BIT]};
            fwd_port_ff <= hit_port;
         end
      end
   end

   // transaction tracking
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         txn_active_ff <= 1'b0;
         auto_write_ff <= 1'b0;
      end else if (addr_valid) begin
         txn_active_ff <= match_hit;
         auto_write_ff <= new_auto_write;
      end else if (txn_stop) begin
         txn_active_ff <= 1'b0;
         auto_write_ff <= 1'b0;
      end
   end

   // data passes untouched
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fwd_data_valid_ff <= 1'b0;
         fwd_data_ff <= 8'h00;
      end else begin
         fwd_data_valid_ff <= data_valid && txn_active_ff;
         if (data_valid && txn_active_ff) begin
            fwd_data_ff <= data_byte;
         end
      end
   end

   // local acknowledge: immediate for auto writes, else from the serializer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         local_ack_valid_ff <= 1'b0;
         local_ack_ff <= 1'b0;
      end else if (new_auto_write || (data_valid && txn_active_ff && auto_write_ff)) begin
         local_ack_valid_ff <= 1'b1;
         local_ack_ff <= 1'b1;
      end else if (remote_ack_valid && txn_active_ff && !auto_write_ff) begin
         local_ack_valid_ff <= 1'b1;
         local_ack_ff <= remote_ack;
      end else begin
         local_ack_valid_ff <= 1'b0;
         local_ack_ff <= 1'b0;
      end
   end

   chk_zero_never_hits: assert property (@(posedge sys_clk) disable iff (rst)
      match_hit |-> alias_ff[hit_port][hit_slot][RAR_ADDR_MSB:RAR_ADDR_LSB] != 7'h00)
      else $error("zero alias reported a match");

   chk_hit_substitutes: assert property (@(posedge sys_clk) disable iff (rst)
      new_hit |=> fwd_addr_valid_ff && fwd_addr_ff[7:1] == $past(hit_phys)
         && fwd_port_ff == $past(hit_port))
      else $error("forwarded address is not the paired target");

   chk_dir_kept: assert property (@(posedge sys_clk) disable iff (rst)
      new_hit |=> fwd_addr_ff[0] == $past(addr_byte[0]))
      else $error("direction bit changed");

   chk_miss_no_fwd: assert property (@(posedge sys_clk) disable iff (rst)
      addr_valid && !match_hit |=> !fwd_addr_valid_ff && miss_ff && !txn_active_ff)
      else $error("unmatched address was forwarded");

   chk_data_kept: assert property (@(posedge sys_clk) disable iff (rst)
      data_valid && txn_active_ff |=> fwd_data_valid_ff && fwd_data_ff == $past(data_byte))
      else $error("data byte not passed unchanged");

   chk_auto_ack_write: assert property (@(posedge sys_clk) disable iff (rst)
      (new_auto_write || (data_valid && txn_active_ff && auto_write_ff))
         |=> local_ack_valid_ff && local_ack_ff)
      else $error("auto write not acknowledged");

   chk_phys_bit0: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd_en && wr_phys_hit && !wr_alias_hit |=> reg_rdata_ff[0] == 1'b0)
      else $error("reserved bit read as one");

   chk_reset_clears: assert property (@(posedge sys_clk)
      rst |=> alias_ff[0][0] == RAR_ALIAS_RESET && phys_ff[NUM_PORTS-1][NUM_SLOTS-1] == 7'h00
         && !fwd_addr_valid_ff && !txn_active_ff)
      else $error("state not cleared by reset");

   chk_port_copy: assert property (@(posedge sys_clk) disable iff (rst)
      reg_wr_en && wr_alias_hit ##1 !reg_wr_en ##1 reg_rd_en && !reg_wr_en
         && reg_addr == $past(reg_addr, 2) && port_sel == $past(port_sel, 2)
         |=> reg_rdata_ff == $past(reg_wdata, 3))
      else $error("alias write not read back from the selected port");

   // register side, forwarded address hold, acknowledge path and transaction close
   chk_slot_window: assert property (@(posedge sys_clk) disable iff (rst)
      wr_alias_hit |-> !wr_phys_hit)
      else $error("alias and target windows overlap");

   chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd_en && !wr_alias_hit && !wr_phys_hit |=> reg_rdata_ff == RAR_UNMAPPED_READ)
      else $error("unmapped offset did not read zero");

   chk_rdata_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !reg_rd_en |=> $stable(reg_rdata_ff))
      else $error("read data changed without a read");

   chk_fwd_holds: assert property (@(posedge sys_clk) disable iff (rst)
      !new_hit |=> $stable(fwd_addr_ff) && $stable(fwd_port_ff))
      else $error("forwarded address changed without a hit");

   chk_auto_ignores_remote: assert property (@(posedge sys_clk) disable iff (rst)
      txn_active_ff && auto_write_ff && !addr_valid && !data_valid |=> !local_ack_valid_ff)
      else $error("remote answer leaked into an auto write");

   chk_remote_ack_passes: assert property (@(posedge sys_clk) disable iff (rst)
      remote_ack_valid && txn_active_ff && !auto_write_ff && !new_auto_write
         |=> local_ack_valid_ff && local_ack_ff == $past(remote_ack))
      else $error("remote answer not passed to the local side");

   chk_ack_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      !addr_valid && !data_valid && !remote_ack_valid |=> !local_ack_valid_ff && !local_ack_ff)
      else $error("acknowledge without a cause");

   chk_stop_closes: assert property (@(posedge sys_clk) disable iff (rst)
      txn_stop && !addr_valid |=> !txn_active_ff && !auto_write_ff)
      else $error("stop did not close the transaction");
endmodule // rar_alias_remap

// ### sim/rar_serializer_model.sv
// far-side serializer answering forwarded bytes with an acknowledge
module rar_serializer_model (
   // clock and forwarded byte strobe
   input wire logic sys_clk,
   input wire logic req,
   // answer delay and value chosen by the bench
   input wire logic [3:0] lag,
   input wire logic ack_val,
   // answer to the hub
   output logic remote_ack_valid,
   output logic remote_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_ff = -1;
   initial begin
      remote_ack_valid = 1'b0;
      remote_ack = 1'b0;
   end
   // idle ack line toggles so a stale value is never mistaken for an answer
   always @(posedge sys_clk) begin
      remote_ack_valid <= (cnt_ff == 0);
      remote_ack <= (cnt_ff == 0) ? ack_val : ~remote_ack;
      if (req) begin
         cnt_ff <= lag;
      end else if (cnt_ff >= 0) begin
         cnt_ff <= cnt_ff - 1;
      end
   end
endmodule // rar_serializer_model

// ### sim/rar_alias_remap_bench.sv
// self-checking bench for the alias remap block
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module rar_alias_remap_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import rar_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic addr_valid = 1'b0, data_valid = 1'b0, txn_stop = 1'b0, p_ack = 1'b0;
   logic remote_ack_valid, remote_ack, fwd_addr_valid_ff, fwd_data_valid_ff, miss_ff;
   logic local_ack_valid_ff, local_ack_ff, txn_active_ff;
   logic [1:0] port_sel = 2'h0, fwd_port_ff;
   logic [3:0] p_lag = 4'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, addr_byte = 8'h00, data_byte = 8'h00;
   logic [7:0] reg_rdata_ff, fwd_addr_ff, fwd_data_ff;
   logic [7:0] al [4][8] = '{default: 8'h00};
   logic [7:0] ph [4][8] = '{default: 8'h00};
   int mismatches = 0, n_compared = 0;
   initial forever #2 sys_clk = ~sys_clk;
   rar_alias_remap dut (.sys_clk(sys_clk), .rst(rst), .port_sel(port_sel),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .addr_valid(addr_valid),
      .addr_byte(addr_byte), .data_valid(data_valid), .data_byte(data_byte),
      .txn_stop(txn_stop), .remote_ack_valid(remote_ack_valid), .remote_ack(remote_ack),
      .fwd_addr_valid_ff(fwd_addr_valid_ff), .fwd_addr_ff(fwd_addr_ff),
      .fwd_port_ff(fwd_port_ff), .fwd_data_valid_ff(fwd_data_valid_ff),
      .fwd_data_ff(fwd_data_ff), .miss_ff(miss_ff), .local_ack_valid_ff(local_ack_valid_ff),
      .local_ack_ff(local_ack_ff), .txn_active_ff(txn_active_ff));
   rar_serializer_model far (.sys_clk(sys_clk), .req(fwd_addr_valid_ff | fwd_data_valid_ff),
      .lag(p_lag), .ack_val(p_ack), .remote_ack_valid(remote_ack_valid),
      .remote_ack(remote_ack));
   function automatic logic [7:0] mval(logic [1:0] p, logic [7:0] a);
      if (a >= RAR_ALIAS_BASE && a < RAR_ALIAS_BASE + 8) return al[p][a - RAR_ALIAS_BASE];
      if (a >= RAR_PHYS_BASE && a < RAR_PHYS_BASE + 8) return ph[p][a - RAR_PHYS_BASE];
      return RAR_UNMAPPED_READ;
   endfunction
   task automatic wr(logic [1:0] p, logic [7:0] a, logic [7:0] d);
      @(posedge sys_clk);
      port_sel <= p;
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      if (a >= RAR_ALIAS_BASE && a < RAR_ALIAS_BASE + 8) al[p][a - RAR_ALIAS_BASE] = d;
      if (a >= RAR_PHYS_BASE && a < RAR_PHYS_BASE + 8) ph[p][a - RAR_PHYS_BASE] = d & 8'hfe;
   endtask
   task automatic rd(logic [1:0] p, logic [7:0] a);
      @(posedge sys_clk);
      port_sel <= p;
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      #1;
      `CHK("reg_rdata", mval(p, a), reg_rdata_ff)
   endtask
   task automatic txn(logic [7:0] ab);
      int hp, hs, k;
      logic auto_w;
      logic [7:0] d;
      hp = -1;
      hs = 0;
      d = 8'($urandom);
      // lowest port and slot wins
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 8; s++) begin
            if (hp < 0 && al[p][s][7:1] != 7'h00 && al[p][s][7:1] == ab[7:1]) begin
               hp = p;
               hs = s;
            end
         end
      end
      @(posedge sys_clk);
      addr_valid <= 1'b1;
      addr_byte <= ab;
      @(posedge sys_clk);
      addr_valid <= 1'b0;
      #1;
      `CHK("miss", hp < 0, miss_ff)
      `CHK("fwd_valid", hp >= 0, fwd_addr_valid_ff)
      `CHK("txn_open", hp >= 0, txn_active_ff)
      if (hp >= 0) begin
         auto_w = al[hp][hs][0] & ~ab[0];
         `CHK("fwd_addr", {ph[hp][hs][7:1], ab[0]}, fwd_addr_ff)
         `CHK("fwd_port", 2'(hp), fwd_port_ff)
         `CHK("addr_ack", {auto_w, auto_w}, {local_ack_valid_ff, local_ack_ff})
         if (auto_w) begin
            @(posedge sys_clk);
            data_valid <= 1'b1;
            data_byte <= d;
            @(posedge sys_clk);
            data_valid <= 1'b0;
            #1;
            `CHK("fwd_data", {1'b1, d}, {fwd_data_valid_ff, fwd_data_ff})
            `CHK("data_ack", 2'b11, {local_ack_valid_ff, local_ack_ff})
         end else begin
            k = 0;
            while (local_ack_valid_ff !== 1'b1 && k < 20) begin
               @(posedge sys_clk);
               #1;
               k++;
            end
            `CHK("remote_ack", {1'b1, p_ack}, {local_ack_valid_ff, local_ack_ff})
         end
      end
      @(posedge sys_clk);
      txn_stop <= 1'b1;
      @(posedge sys_clk);
      txn_stop <= 1'b0;
      #1;
      `CHK("txn_closed", 1'b0, txn_active_ff)
      // let any late serializer answer die out
      repeat (10) @(posedge sys_clk);
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      close_out;
   end
   initial begin
      logic [1:0] p;
      int s;
      logic [7:0] av;
      void'($urandom(32'h2b23e051));
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++) rd(2'($urandom), 8'(RAR_PHYS_BASE + a));
      wr(2'h0, 8'h4c, 8'hff);
      rd(2'h0, 8'h4c);
      txn(8'h00);
      txn(8'($urandom));
      $display("test reset_state done");
      wr(2'h1, RAR_REMOTE_TARGET_ADDR_6, 8'hff);
      wr(2'h2, RAR_LOCAL_ALIAS_ADDR_1, 8'h5b);
      rd(2'h1, RAR_REMOTE_TARGET_ADDR_6);
      rd(2'h0, RAR_REMOTE_TARGET_ADDR_6);
      rd(2'h3, RAR_LOCAL_ALIAS_ADDR_1);
      $display("test port_copies done");
      repeat (40) begin
         p = 2'($urandom);
         s = $urandom % 8;
         av = ($urandom % 5 == 0) ? 8'h00 : 8'($urandom);
         wr(p, 8'(RAR_ALIAS_BASE + s), av);
         rd(p, 8'(RAR_ALIAS_BASE + s));
         wr(p, 8'(RAR_PHYS_BASE + s), 8'($urandom));
         rd(p, 8'(RAR_PHYS_BASE + s));
         p_lag <= 4'($urandom % 8);
         p_ack <= 1'($urandom);
         txn(($urandom % 2) ? {av[7:1], 1'($urandom)} : 8'($urandom));
      end
      $display("test random_remap done");
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      al = '{default: 8'h00};
      ph = '{default: 8'h00};
      for (int a = 0; a < 16; a++) rd(2'($urandom), 8'(RAR_PHYS_BASE + a));
      txn({av[7:1], 1'b0});
      $display("test mid_reset done");
      close_out;
   end
endmodule // rar_alias_remap_bench
